// *** rtl/vcs_params.svh ***
// Purpose: constants for the voltage code soft-start sequencer
// Assumes: 12.5 mV reference units, counts in switching cycles
// Notes:   included by bare name
`ifndef VCS_PARAMS_SVH
`define VCS_PARAMS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define VCS_ADDR_CTRL        8'h00
`define VCS_ADDR_STATUS      8'h04
`define VCS_CTRL_RST         16'h0021
`define VCS_ST_STATE_LSB     0
`define VCS_ST_TRIP_BIT      3
`define VCS_ST_POK_BIT       4
`define VCS_ST_DRIVE_BIT     5
`define VCS_ST_REF_LSB       8
`define VCS_ST_TGT_LSB       16

// ----------------------------------------------------------------
// code decode
// ----------------------------------------------------------------
`define VCS_CODE_OFF_A       6'h3f
`define VCS_CODE_OFF_B       6'h3e
`define VCS_CODE_LO_MAX      6'h14
`define VCS_LO_BASE          8'h57
`define VCS_HI_BASE          8'h95

// ----------------------------------------------------------------
// timing in switching cycles and sixths
// ----------------------------------------------------------------
`define VCS_SIXTHS_LAST      3'h5
`define VCS_HALF_SIXTHS      2'h3
`define VCS_SS_DELAY         11'h040
`define VCS_SS_COARSE_END    11'h2c0
`define VCS_COARSE_PERIOD    5'h1f
`define VCS_FINE_PERIOD      5'h0f
`define VCS_COARSE_INC       8'h02
`define VCS_FINE_INC         8'h01
`define VCS_OFS_START        4'h8
`define VCS_OFS_PERIOD       7'h4f
`define VCS_NOLOAD_CYC       2'h2

`endif

// *** rtl/vcs_pkg.sv ***
// Purpose: shared types of the voltage code soft-start sequencer
// Assumes: nothing
// Notes:   states in binary
package vcs_pkg;
  typedef enum logic [2:0] {
    VCS_S_OFF   = 3'h0,
    VCS_S_DELAY = 3'h1,
    VCS_S_RAMP  = 3'h2,
    VCS_S_REG   = 3'h3,
    VCS_S_TRIP  = 3'h4
  } vcs_state_t;
endpackage

// *** rtl/vcs_tick_if.sv ***
// Purpose: carries switching-cycle timing strobes between modules
// Assumes: one clock
// Notes:   strobes are one pclk cycle wide
`timescale 1ns/1ps
`default_nettype none
interface vcs_tick_if;
  logic        sixth_stb;  // one of six samples per switching cycle
  logic        cycle_stb;  // last sixth of each switching cycle
  modport src (output sixth_stb, output cycle_stb);
  modport dst (input sixth_stb, input cycle_stb);
endinterface
`default_nettype wire

// *** rtl/vcs_tick.sv ***
// Purpose: divides pclk into sixths of a switching cycle
// Assumes: sixth_div is pclk cycles per sixth, minus one
// Notes:   six sixths make one switching cycle
`timescale 1ns/1ps
`default_nettype none
`include "vcs_params.svh"
module vcs_tick (
  input  wire logic        pclk,      // system clock
  input  wire logic        presetn,   // async reset, low
  input  wire logic [15:0] sixth_div, // divider reload
  vcs_tick_if.src          tick       // strobes out
);
  logic [15:0] div_reg;
  logic [15:0] div_next;
  logic [2:0]  ph_reg;
  logic [2:0]  ph_next;
  logic        stb;

  // -----------------------------------------------------------
  // divider and phase counter
  // -----------------------------------------------------------
  always_comb begin
    stb      = (div_reg >= sixth_div);
    div_next = stb ? 16'h0000 : div_reg + 16'h0001;
    ph_next  = ph_reg;
    if (stb) begin
      ph_next = (ph_reg == `VCS_SIXTHS_LAST) ? 3'h0 : ph_reg + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 16'h0000;
      ph_reg  <= 3'h0;
    end else begin
      div_reg <= div_next;
      ph_reg  <= ph_next;
    end
  end

  // strobes
  assign tick.sixth_stb = stb;
  assign tick.cycle_stb = stb && (ph_reg == `VCS_SIXTHS_LAST);
endmodule
`default_nettype wire

// *** rtl/vcs_code_decode.sv ***
// Purpose: maps the six-bit voltage code to a reference level
// Assumes: level in 12.5 mV units from zero
// Notes:   the two highest codes, 3f and 3e, mean no load
`timescale 1ns/1ps
`default_nettype none
`include "vcs_params.svh"
module vcs_code_decode (
  input  wire logic [5:0] code,   // synchronised voltage code
  output logic      [7:0] level,  // target reference level
  output logic            off     // no-load code seen
);
  // -----------------------------------------------------------
  // table walk: code falls as level rises, in two runs
  // -----------------------------------------------------------
  always_comb begin
    off   = (code == `VCS_CODE_OFF_A) || (code == `VCS_CODE_OFF_B);
    level = 8'h00;
    if (off) begin
      level = 8'h00;
    end else if (code <= `VCS_CODE_LO_MAX) begin
      level = `VCS_LO_BASE - {2'b00, code};
    end else begin
      level = `VCS_HI_BASE - {2'b00, code};
    end
  end
endmodule
`default_nettype wire

// *** rtl/vcs_seq.sv ***
// Purpose: start-up gating, soft-start and code tracking sequencer
// Assumes: analog comparators arrive as asynchronous logic levels
// Notes:   APB slave, zero wait states, reference in 12.5 mV units
//
// Functional notes
// [R1] sample the code six times per switching cycle, compare to reference
// [R2] on a difference, wait half a cycle, then step one 12.5 mV
// [R3] if the difference changes during the wait, cancel the step
// [R4] difference above one step: six steps per cycle until equal
// [R5] processor steps the code one step at a time, at a steady rate
// [R6] in shutdown every PWM output is high impedance
// [R7] start at once when supply, threshold, logic enable ok, code not off
// [R8] a no-load code shuts down; another code restarts soft-start
// [R9] two cycles after a no-load code, shutdown trip level, PWM off
// [R10] no-load codes never clear a latched overvoltage shutdown
// [R11] system holds us disabled until drivers finish power-on reset
// [R12] soft-start ramps the reference linearly from zero to target
// [R13] PWM stays high impedance until reference reaches the output
// [R14] soft-start: 64-cycle delay, then 1280 cycles per volt ramp
// [R15] 100 mV sense offset decays to zero over first 640 ramp cycles
// [R16] 25 mV steps in first 640 ramp cycles, 12.5 mV afterwards
// [R17] power ok released after soft-start with output in window
// [R18] reference decoded from code table, 0.8375 V to 1.600 V
// [R19] overvoltage trip halts PWM until an enable or supply cycles
// [R20] any enable lapse returns to shutdown; restart from zero
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "vcs_params.svh"
module vcs_seq (
  input  wire logic        pclk,               // 200 MHz clock
  input  wire logic        presetn,            // async reset, low
  input  wire logic        psel,               // apb select
  input  wire logic        penable,            // apb access phase
  input  wire logic        pwrite,             // apb write
  input  wire logic [7:0]  paddr,              // apb byte address
  input  wire logic [31:0] pwdata,             // apb write data
  output logic      [31:0] prdata,             // apb read data
  output logic             pready,             // apb ready
  output logic             pslverr,            // apb error
  input  wire logic [5:0]  voltage_code,       // code pins
  input  wire logic        supply_ok_in,       // supply above reset level
  input  wire logic        threshold_en_in,    // enable comparator high
  input  wire logic        logic_enable_in,    // logic enable pin
  input  wire logic        ov_detect_in,       // overvoltage comparator
  input  wire logic        out_reached_in,     // reference >= output
  input  wire logic        in_window_in,       // output in window
  input  wire logic [3:0]  pwm_mod_in,         // modulator phases
  output logic      [3:0]  pwm_out,            // phase drive level
  output logic      [3:0]  pwm_oe_n,           // low drives phase pins
  output logic             power_ok_out,       // open-drain level
  output logic             power_ok_oe_n,      // low pulls power ok
  output logic             overvoltage_trip,   // crowbar drive
  output logic             ovp_level_shutdown, // trip level select
  output logic      [7:0]  ref_level_out,      // reference level
  output logic      [3:0]  sense_offset_out    // offset, 12.5 mV units
);
  localparam int SYN_W = 12;

  // -----------------------------------------------------------
  // input synchronisers
  // -----------------------------------------------------------
  logic [SYN_W-1:0] pin_raw;
  logic [SYN_W-1:0] syn1_reg;
  logic [SYN_W-1:0] syn2_reg;
  assign pin_raw = {voltage_code, supply_ok_in, threshold_en_in,
                    logic_enable_in, ov_detect_in, out_reached_in,
                    in_window_in};

  // two flops per pin; only the second is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      syn1_reg <= '0;
      syn2_reg <= '0;
    end else begin
      syn1_reg <= pin_raw;
      syn2_reg <= syn1_reg;
    end
  end

  logic [5:0] code_s;
  logic       sup_s;
  logic       thr_s;
  logic       len_s;
  logic       ov_s;
  logic       reach_s;
  logic       win_s;
  assign {code_s, sup_s, thr_s, len_s, ov_s, reach_s, win_s} = syn2_reg;

  // -----------------------------------------------------------
  // timing and decode
  // -----------------------------------------------------------
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic [7:0]  target;
  logic        off_code;
  vcs_tick_if  tick ();

  vcs_tick u_tick (
    .pclk      (pclk),
    .presetn   (presetn),
    .sixth_div (ctrl_reg),
    .tick      (tick.src)
  );

  // [R18] table decode
  vcs_code_decode u_dec (
    .code  (code_s),
    .level (target),
    .off   (off_code)
  );

  // -----------------------------------------------------------
  // sequencer state
  // -----------------------------------------------------------
  vcs_pkg::vcs_state_t state_reg;
  vcs_pkg::vcs_state_t state_next;
  logic [10:0] ss_reg;
  logic [10:0] ss_next;
  logic [4:0]  stp_reg;
  logic [4:0]  stp_next;
  logic [6:0]  ofc_reg;
  logic [6:0]  ofc_next;
  logic [3:0]  ofs_reg;
  logic [3:0]  ofs_next;
  logic [7:0]  ref_reg;
  logic [7:0]  ref_next;
  logic [1:0]  nl_reg;
  logic [1:0]  nl_next;
  logic        trip_reg;
  logic        trip_next;
  logic        drv_reg;
  logic        drv_next;
  logic        pend_reg;
  logic        pend_next;
  logic        slew_reg;
  logic        slew_next;
  logic [1:0]  wt_reg;
  logic [1:0]  wt_next;
  logic [8:0]  pdif_reg;
  logic [8:0]  pdif_next;
  logic [8:0]  diff;
  logic [7:0]  ramp_inc;
  logic [4:0]  ramp_per;
  logic [8:0]  ramp_sum;
  logic        en_ok;
  logic        coarse;
  logic        active;

  assign en_ok  = sup_s && thr_s && len_s;
  assign coarse = (ss_reg < `VCS_SS_COARSE_END);
  assign active = (state_reg == vcs_pkg::VCS_S_DELAY) ||
                  (state_reg == vcs_pkg::VCS_S_RAMP) ||
                  (state_reg == vcs_pkg::VCS_S_REG);
  assign diff   = {1'b0, target} - {1'b0, ref_reg};

  // next state of sequencer, ramp, offset and code tracking
  always_comb begin
    state_next = state_reg;
    ss_next    = ss_reg;
    stp_next   = stp_reg;
    ofc_next   = ofc_reg;
    ofs_next   = ofs_reg;
    ref_next   = ref_reg;
    nl_next    = nl_reg;
    trip_next  = trip_reg;
    drv_next   = drv_reg;
    pend_next  = pend_reg;
    slew_next  = slew_reg;
    wt_next    = wt_reg;
    pdif_next  = pdif_reg;
    ramp_inc   = coarse ? `VCS_COARSE_INC : `VCS_FINE_INC;
    ramp_per   = coarse ? `VCS_COARSE_PERIOD : `VCS_FINE_PERIOD;
    ramp_sum   = {1'b0, ref_reg} + {1'b0, ramp_inc};
    // [R8] no-load wait counts whole cycles while active
    if (!off_code || !active) begin
      nl_next = 2'h0;
    end else if (tick.cycle_stb && nl_reg != `VCS_NOLOAD_CYC) begin
      nl_next = nl_reg + 2'h1;
    end
    case (state_reg)
      vcs_pkg::VCS_S_OFF: begin
        // [R7] immediate start when all enables hold
        if (en_ok && !off_code && !trip_reg) begin
          state_next = vcs_pkg::VCS_S_DELAY;
        end
      end
      vcs_pkg::VCS_S_DELAY: begin
        // [R14] hold reference at zero for 64 cycles
        if (tick.cycle_stb) begin
          ss_next = ss_reg + 11'h001;
          if (ss_next == `VCS_SS_DELAY) begin
            state_next = vcs_pkg::VCS_S_RAMP;
          end
        end
      end
      vcs_pkg::VCS_S_RAMP: begin
        // [R13] start switching once reference meets output
        if (reach_s) begin
          drv_next = 1'b1;
        end
        if (tick.cycle_stb) begin
          if (coarse) begin
            ss_next = ss_reg + 11'h001;
          end
          // [R15] offset decays one unit every 80 cycles
          if (ofs_reg != 4'h0) begin
            ofc_next = (ofc_reg == `VCS_OFS_PERIOD) ? 7'h00
                                                     : ofc_reg + 7'h01;
            if (ofc_reg == `VCS_OFS_PERIOD) begin
              ofs_next = ofs_reg - 4'h1;
            end
          end
          // [R12] [R16] linear ramp, coarse then fine steps
          stp_next = (stp_reg >= ramp_per) ? 5'h00 : stp_reg + 5'h01;
          if (stp_reg >= ramp_per) begin
            ref_next = (ramp_sum >= {1'b0, target}) ? target
                                                    : ramp_sum[7:0];
          end
        end
        if (ref_reg >= target && target != 8'h00) begin
          ref_next   = target;
          state_next = vcs_pkg::VCS_S_REG;
        end
      end
      vcs_pkg::VCS_S_REG: begin
        drv_next = 1'b1;
        // [R1] compare on each of six samples per cycle
        if (tick.sixth_stb && !off_code) begin
          if (diff == 9'h000) begin
            pend_next = 1'b0;
            slew_next = 1'b0;
          end else if (slew_reg) begin
            // [R4] back-to-back steps at every sample
            ref_next = diff[8] ? ref_reg - 8'h01 : ref_reg + 8'h01;
          end else if (!pend_reg) begin
            pend_next = 1'b1;
            pdif_next = diff;
            wt_next   = 2'h1;
          end else if (diff != pdif_reg) begin
            // [R3] difference moved, drop the step
            pend_next = 1'b0;
          end else if (wt_reg == `VCS_HALF_SIXTHS) begin
            // [R2] half cycle passed, one step toward the code
            ref_next  = diff[8] ? ref_reg - 8'h01 : ref_reg + 8'h01;
            pend_next = 1'b0;
            slew_next = (diff != 9'h001) && (diff != 9'h1ff);
          end else begin
            wt_next = wt_reg + 2'h1;
          end
        end
      end
      vcs_pkg::VCS_S_TRIP: begin
        drv_next = 1'b0;
      end
      default: begin
        state_next = vcs_pkg::VCS_S_OFF;
      end
    endcase
    // [R9] two cycles after a no-load code, shut down
    if (active && off_code && nl_reg == `VCS_NOLOAD_CYC) begin
      state_next = vcs_pkg::VCS_S_OFF;
    end
    // [R10] [R19] trip latch, released only by an enable lapse
    if (!en_ok) begin
      trip_next = 1'b0;
    end
    if (ov_s && sup_s) begin
      trip_next  = 1'b1;
      state_next = vcs_pkg::VCS_S_TRIP;
    end else if (!en_ok) begin
      // [R20] lapse returns to shutdown
      state_next = vcs_pkg::VCS_S_OFF;
    end else if (trip_reg) begin
      state_next = vcs_pkg::VCS_S_TRIP;
    end
    // [R20] every fresh start begins from zero
    if (state_next == vcs_pkg::VCS_S_OFF ||
        state_next == vcs_pkg::VCS_S_TRIP) begin
      ss_next   = 11'h000;
      stp_next  = 5'h00;
      ofc_next  = 7'h00;
      ofs_next  = `VCS_OFS_START;
      ref_next  = 8'h00;
      drv_next  = 1'b0;
      pend_next = 1'b0;
      slew_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= vcs_pkg::VCS_S_OFF;
      ss_reg    <= 11'h000;
      stp_reg   <= 5'h00;
      ofc_reg   <= 7'h00;
      ofs_reg   <= `VCS_OFS_START;
      ref_reg   <= 8'h00;
      nl_reg    <= 2'h0;
      trip_reg  <= 1'b0;
      drv_reg   <= 1'b0;
      pend_reg  <= 1'b0;
      slew_reg  <= 1'b0;
      wt_reg    <= 2'h0;
      pdif_reg  <= 9'h000;
    end else begin
      state_reg <= state_next;
      ss_reg    <= ss_next;
      stp_reg   <= stp_next;
      ofc_reg   <= ofc_next;
      ofs_reg   <= ofs_next;
      ref_reg   <= ref_next;
      nl_reg    <= nl_next;
      trip_reg  <= trip_next;
      drv_reg   <= drv_next;
      pend_reg  <= pend_next;
      slew_reg  <= slew_next;
      wt_reg    <= wt_next;
      pdif_reg  <= pdif_next;
    end
  end

  // -----------------------------------------------------------
  // pin outputs
  // -----------------------------------------------------------
  logic [3:0] pwm_reg;
  logic [3:0] pwm_next;
  logic [3:0] pwe_reg;
  logic [3:0] pwe_next;
  logic       pok_reg;
  logic       pok_next;
  logic       ovl_reg;
  logic       ovl_next;

  // phase drive: hi-z when off, low in trip while overvoltage is seen
  always_comb begin
    pwm_next = pwm_mod_in;
    pwe_next = 4'hf;
    // [R6] [R13] drive low in trip on overvoltage, else only once switching is allowed
    if (state_reg == vcs_pkg::VCS_S_TRIP && ov_s) begin
      pwm_next = 4'h0;
      pwe_next = 4'h0;
    end else if (drv_reg) begin
      pwe_next = 4'h0;
    end
    // [R17] released after soft-start with output in window
    pok_next = (state_reg == vcs_pkg::VCS_S_REG) && win_s;
    ovl_next = (state_reg == vcs_pkg::VCS_S_OFF);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_reg <= 4'h0;
      pwe_reg <= 4'hf;
      pok_reg <= 1'b0;
      ovl_reg <= 1'b1;
    end else begin
      pwm_reg <= pwm_next;
      pwe_reg <= pwe_next;
      pok_reg <= pok_next;
      ovl_reg <= ovl_next;
    end
  end

  assign pwm_out            = pwm_reg;
  assign pwm_oe_n           = pwe_reg;
  assign power_ok_out       = 1'b0;
  assign power_ok_oe_n      = pok_reg;
  assign overvoltage_trip   = trip_reg;
  assign ovp_level_shutdown = ovl_reg;
  assign ref_level_out      = ref_reg;
  assign sense_offset_out   = ofs_reg;

  // -----------------------------------------------------------
  // apb slave
  // -----------------------------------------------------------
  logic [31:0] rd_reg;
  logic [31:0] rd_next;
  logic        err_reg;
  logic        err_next;
  logic [31:0] status;
  logic        setup;

  assign setup = psel && !penable;
  always_comb begin
    status = 32'h0000_0000;
    status[`VCS_ST_STATE_LSB +: 3] = state_reg;
    status[`VCS_ST_TRIP_BIT]       = trip_reg;
    status[`VCS_ST_POK_BIT]        = pok_reg;
    status[`VCS_ST_DRIVE_BIT]      = drv_reg;
    status[`VCS_ST_REF_LSB +: 8]   = ref_reg;
    status[`VCS_ST_TGT_LSB +: 8]   = target;
  end

  // read data and error latched in the setup cycle
  always_comb begin
    rd_next   = rd_reg;
    err_next  = err_reg;
    ctrl_next = ctrl_reg;
    if (setup) begin
      err_next = 1'b0;
      rd_next  = 32'h0000_0000;
      case (paddr)
        `VCS_ADDR_CTRL:   rd_next = {16'h0000, ctrl_reg};
        `VCS_ADDR_STATUS: rd_next = status;
        default:          err_next = 1'b1;
      endcase
    end
    if (psel && penable && pwrite && paddr == `VCS_ADDR_CTRL) begin
      ctrl_next = pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_reg   <= 32'h0000_0000;
      err_reg  <= 1'b0;
      ctrl_reg <= `VCS_CTRL_RST;
    end else begin
      rd_reg   <= rd_next;
      err_reg  <= err_next;
      ctrl_reg <= ctrl_next;
    end
  end

  assign prdata  = rd_reg;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && err_reg;

  // -----------------------------------------------------------
  // assertions
  // -----------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  off_hiz_a: assert property ( // [R6]
    state_reg == vcs_pkg::VCS_S_OFF |=> pwm_oe_n == 4'hf)
    else $error("phase pins driven in shutdown");
  start_now_a: assert property ( // [R7]
    state_reg == vcs_pkg::VCS_S_OFF && en_ok && !off_code && !trip_reg
    && !ov_s |=> state_reg == vcs_pkg::VCS_S_DELAY)
    else $error("start not taken at once");
  delay_len_a: assert property ( // [R14]
    $rose(state_reg == vcs_pkg::VCS_S_RAMP) |-> ss_reg == `VCS_SS_DELAY)
    else $error("start delay not 64 cycles");
  fine_step_a: assert property ( // [R16]
    state_reg == vcs_pkg::VCS_S_RAMP && !coarse
    |=> ref_reg <= $past(ref_reg) + 8'h01)
    else $error("fine ramp step too large");
  noload_off_a: assert property ( // [R9]
    active && off_code && nl_reg == `VCS_NOLOAD_CYC
    |=> state_reg != vcs_pkg::VCS_S_REG ##1 pwm_oe_n == 4'hf)
    else $error("no-load code did not shut down");
  trip_hold_a: assert property ( // [R10]
    trip_reg && en_ok |=> trip_reg)
    else $error("trip latch cleared without enable lapse");
  pok_cause_a: assert property ( // [R17]
    power_ok_oe_n |-> $past(state_reg == vcs_pkg::VCS_S_REG && win_s))
    else $error("power ok released outside regulation");
  one_step_a: assert property ( // [R2]
    state_reg == vcs_pkg::VCS_S_REG ##1 state_reg == vcs_pkg::VCS_S_REG
    |-> ref_reg - $past(ref_reg) inside {8'h00, 8'h01, 8'hff})
    else $error("tracking moved more than one step");
  cancel_a: assert property ( // [R3]
    state_reg == vcs_pkg::VCS_S_REG && tick.sixth_stb && pend_reg
    && !slew_reg && diff != pdif_reg && diff != 9'h000 && !off_code
    && en_ok && !trip_reg && !ov_s |=> !pend_reg && $stable(ref_reg))
    else $error("changed difference did not cancel");
  lapse_a: assert property ( // [R20]
    !en_ok && !(ov_s && sup_s) |=> state_reg == vcs_pkg::VCS_S_OFF
    && ref_reg == 8'h00)
    else $error("enable lapse did not reset");

  reach_reg_c: cover property (
    $rose(state_reg == vcs_pkg::VCS_S_REG));
  trip_c: cover property ($rose(trip_reg));
  track_c: cover property (
    state_reg == vcs_pkg::VCS_S_REG && $changed(ref_reg));
  cancel_c: cover property (
    pend_reg ##1 !pend_reg && $stable(ref_reg));
endmodule
`default_nettype wire

// *** bench/vcs_cpu_model.sv ***
// Purpose: processor side that drives the voltage code pins
// Assumes: goal stays within codes 21..61 unless jumping
// Notes:   jump loads the goal at once for tracking and no-load tests
`timescale 1ns/1ps
`default_nettype none
module vcs_cpu_model (
  input  wire logic       pclk,         // system clock
  input  wire logic [5:0] goal,         // wanted code
  input  wire logic       jump,         // load goal at once
  output logic      [5:0] voltage_code  // code pins
);
  logic [5:0] gap_cnt;  // pacing between steps
  initial begin
    voltage_code = 6'h15;
    gap_cnt = 6'h00;
  end
  // one code step per pacing period
  always @(posedge pclk) begin
    gap_cnt <= gap_cnt + 6'h01;
    if (jump)
      voltage_code <= goal;
    else if (gap_cnt == 6'h00 && voltage_code != goal)
      voltage_code <= (voltage_code < goal) ? voltage_code + 6'h01
                                            : voltage_code - 6'h01;
  end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Purpose: self-checking bench for the soft-start sequencer
// Assumes: sixth divider set to zero, six pclk per cycle
// Notes:   apb master, random pwm levels and goal
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, er, jump = 1'b0;
  logic supply_ok_in = 1'b0, threshold_en_in = 1'b0;
  logic logic_enable_in = 1'b0, ov_detect_in = 1'b0;
  logic out_reached_in = 1'b0, in_window_in = 1'b0;
  logic power_ok_out, power_ok_oe_n, overvoltage_trip, ovp_level_shutdown;
  logic [7:0] paddr = 8'h00, ref_level_out;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hc40b;
  logic [5:0] voltage_code, goal = 6'h15;
  logic [3:0] pwm_mod_in = 4'h0, pwm_out, pwm_oe_n, sense_offset_out, pm_d;
  int fail_count = 0, comparisons = 0, cyc = 0;
  always #2.5 pclk = ~pclk;
  vcs_seq vcs_seq_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .voltage_code,
    .supply_ok_in, .threshold_en_in, .logic_enable_in, .ov_detect_in,
    .out_reached_in, .in_window_in, .pwm_mod_in, .pwm_out, .pwm_oe_n,
    .power_ok_out, .power_ok_oe_n, .overvoltage_trip,
    .ovp_level_shutdown, .ref_level_out, .sense_offset_out);
  vcs_cpu_model vcs_cpu_model_inst (.pclk, .goal, .jump, .voltage_code);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // expected reference level of a code
  function automatic logic [7:0] lvl(input logic [5:0] c);
    return (c <= 6'h14) ? 8'h57 - c : 8'h95 - c;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // poll status until the masked field matches
  task automatic wst(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin apb(1'b0, 8'h04); n++; end while ((rd & m) !== v && n < 8000);
    chk(rd & m, v);
  endtask
  // load a code at once through the processor model
  task automatic set_code(input logic [5:0] c);
    goal <= c;
    jump <= 1'b1;
    @(posedge pclk);
    jump <= 1'b0;
  endtask
  // random pwm levels, hang guard
  always @(posedge pclk) begin
    seed <= xs(seed);
    pwm_mod_in <= seed[3:0];
    pm_d <= pwm_mod_in;
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk(pwm_oe_n, 4'hf);
    chk(ovp_level_shutdown, 1'b1);
    apb(1'b1, 8'h00);
    apb(1'b0, 8'h00);
    chk(rd, 32'h0);
    apb(1'b0, 8'h08);
    chk(er, 1'b1);
    chk(pready, 1'b1);
    // enables released only once drivers are up
    supply_ok_in <= 1'b1;
    threshold_en_in <= 1'b1;
    logic_enable_in <= 1'b1;
    wst(32'h7, 32'h1);
    wst(32'h7, 32'h2);
    chk(pwm_oe_n, 4'hf);
    chk(sense_offset_out, 4'h8);
    out_reached_in <= 1'b1;
    in_window_in <= 1'b1;
    wst(32'h7, 32'h3);
    chk(ref_level_out, 8'h80);
    chk(sense_offset_out, 4'h0);
    chk(pwm_oe_n, 4'h0);
    @(negedge pclk);
    chk(pwm_out, pm_d);
    repeat (2) @(posedge pclk);
    chk(power_ok_oe_n, 1'b1);
    chk(power_ok_out, 1'b0);
    $display("soft-start test done");
    goal <= 6'd21 + 6'(seed % 41);
    @(posedge pclk);
    wst(32'hff00, {16'h0, lvl(goal), 8'h00});
    set_code(6'h20);
    wst(32'hff00, {16'h0, lvl(6'h20), 8'h00});
    $display("tracking test done");
    set_code(6'h3f);
    repeat (6) @(posedge pclk);
    chk(pwm_oe_n, 4'h0);
    chk(ovp_level_shutdown, 1'b0);
    wst(32'h7, 32'h0);
    chk(pwm_oe_n, 4'hf);
    chk(ovp_level_shutdown, 1'b1);
    set_code(6'h15);
    wst(32'h7, 32'h1);
    chk(ref_level_out, 8'h00);
    $display("no-load test done");
    // trip holds through no-load codes until an enable cycles
    ov_detect_in <= 1'b1;
    wst(32'hf, 32'hc);
    chk(overvoltage_trip, 1'b1);
    chk(pwm_oe_n, 4'h0);
    chk(pwm_out, 4'h0);
    ov_detect_in <= 1'b0;
    set_code(6'h3f);
    repeat (20) @(posedge pclk);
    set_code(6'h15);
    repeat (20) @(posedge pclk);
    wst(32'hf, 32'hc);
    chk(pwm_oe_n, 4'hf);
    logic_enable_in <= 1'b0;
    wst(32'hf, 32'h0);
    chk(overvoltage_trip, 1'b0);
    logic_enable_in <= 1'b1;
    wst(32'h7, 32'h1);
    $display("trip test done");
    final_report();
  end
endmodule
`default_nettype wire
